// File: hw/xrd_bit_reverse.sv
// Optional bit-order reversal of each LANE_W-bit lane symbol in a bus
`timescale 1ns/1ps
module xrd_bit_reverse #(
    parameter int LANES = 4,
    parameter int LANE_W = 10
) (
    input wire logic enable,
    input wire logic [LANES*LANE_W-1:0] din,
    output logic [LANES*LANE_W-1:0] dout
);
    // Mirror each lane's bits when enabled; pure wiring otherwise
    always_comb begin
        dout = din;
        if (enable) begin
            for (int l = 0; l < LANES; l++) begin
                for (int b = 0; b < LANE_W; b++) begin
                    dout[l*LANE_W+b] = din[l*LANE_W+LANE_W-1-b];
                end
            end
        end
    end
endmodule : xrd_bit_reverse

// File: hw/xrd_diag_regs.sv
// Diagnostic register bank with bit reversal and loopback datapath steering
`timescale 1ns/1ps
`include "xrd_map.svh"
module xrd_diag_regs
    import xrd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire xrd_mgmt_req_t mgmt_req,
    output logic [15:0] mgmt_rdata,
    output logic mgmt_rvalid,
    input wire logic std_loopback,
    input wire logic align_status,
    input wire logic [3:1] code_err,
    input wire logic [11:0] sync_fsm_state,
    input wire logic [3:0] align_fsm_state,
    input wire logic align_fifo_collision,
    input wire logic all_lanes_synced,
    input wire xrd_xgmii_t xgmii_tx_in,
    output xrd_xgmii_t xgmii_tx_core,
    input wire xrd_xgmii_t rx_decoded,
    output xrd_xgmii_t xgmii_rx_out,
    input wire logic [39:0] tx_encoded,
    output logic [39:0] serdes_tx_out,
    input wire logic [39:0] serdes_rx_a,
    input wire logic [39:0] serdes_rx_b,
    output logic [39:0] rx_core_a,
    output logic [39:0] rx_core_b,
    output logic [3:0] bit_rev_ctrl,
    output logic [1:0] loop_ctrl
);
    logic [3:0] bit_rev_reg;
    logic [3:0] bit_rev_next;
    logic [1:0] loop_reg;
    logic [1:0] loop_next;
    logic coll_latch_reg;
    logic coll_latch_next;
    logic sync_latch_reg;
    logic sync_latch_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    xrd_rd_state_t rd_state_reg;
    xrd_rd_state_t rd_state_next;
    logic [3:1] cnt_clear;
    logic [15:0] cnt_val [3:1];
    logic rd_align;
    logic rd_sync;
    logic xaui_loop_on;
    logic xgmii_loop_on;
    logic [31:0] rx_rev_data;
    logic [39:0] rx_a_rev;
    logic [39:0] rx_b_rev;
    logic [39:0] tx_rev;
    logic [39:0] rx_a_sel;
    xrd_xgmii_t tx_src;
    xrd_xgmii_t tx_core_reg;
    xrd_xgmii_t rx_out_reg;
    logic [39:0] ser_tx_reg;
    logic [39:0] rx_a_reg;
    logic [39:0] rx_b_reg;

    // Read strobes for the three counters and the two latched status registers; counters clear on the same read
    always_comb begin
        cnt_clear[1] = mgmt_req.rd && mgmt_req.addr == `XRD_ADDR_LANE1_CNT;
        cnt_clear[2] = mgmt_req.rd && mgmt_req.addr == `XRD_ADDR_LANE2_CNT;
        cnt_clear[3] = mgmt_req.rd && mgmt_req.addr == `XRD_ADDR_LANE3_CNT;
        rd_align = mgmt_req.rd && mgmt_req.addr == `XRD_ADDR_ALIGN_STAT;
        rd_sync = mgmt_req.rd && mgmt_req.addr == `XRD_ADDR_SYNC_STAT;
    end

    // One counter per lane 1..3
    for (genvar g = 1; g <= 3; g++) begin : g_cnt
        xrd_lane_counter #(.WIDTH(16)) u_cnt (
            .clk_sys(clk_sys),
            .reset_n(reset_n),
            .code_err(code_err[g]),
            .aligned(align_status),
            .rd_clear(cnt_clear[g]),
            .count(cnt_val[g])
        );
    end

    // Control writes and latched status; a new event beats the read-clear
    always_comb begin
        bit_rev_next = bit_rev_reg;
        loop_next = loop_reg;
        if (mgmt_req.wr && mgmt_req.addr == `XRD_ADDR_BIT_REV) begin
            bit_rev_next = mgmt_req.wdata[3:0];
        end
        if (mgmt_req.wr && mgmt_req.addr == `XRD_ADDR_LOOP_CTRL) begin
            loop_next = mgmt_req.wdata[1:0];
        end
        coll_latch_next = coll_latch_reg | align_fifo_collision;
        if (rd_align) begin
            coll_latch_next = align_fifo_collision;
        end
        sync_latch_next = sync_latch_reg & all_lanes_synced;
        if (rd_sync) begin
            sync_latch_next = all_lanes_synced;
        end
    end

    // Read data mux, registered one cycle after the strobe
    always_comb begin
        rdata_next = rdata_reg;
        rvalid_next = 1'b0;
        rd_state_next = XRD_IDLE;
        case (rd_state_reg)
            XRD_IDLE, XRD_ANSWER: begin
                if (mgmt_req.rd) begin
                    rvalid_next = 1'b1;
                    rd_state_next = XRD_ANSWER;
                    rdata_next = `XRD_ZERO16;
                    case (mgmt_req.addr)
                        `XRD_ADDR_LANE1_CNT: rdata_next = cnt_val[1];
                        `XRD_ADDR_LANE2_CNT: rdata_next = cnt_val[2];
                        `XRD_ADDR_LANE3_CNT: rdata_next = cnt_val[3];
                        `XRD_ADDR_SYNC_STATE: rdata_next = {4'h0, sync_fsm_state};
                        `XRD_ADDR_ALIGN_STAT: begin
                            rdata_next = {align_fsm_state, 11'h000, coll_latch_reg};
                        end
                        `XRD_ADDR_SYNC_STAT: rdata_next = {4'h0, sync_latch_reg, 11'h000};
                        `XRD_ADDR_BIT_REV: rdata_next = {12'h000, bit_rev_reg};
                        `XRD_ADDR_LOOP_CTRL: rdata_next = {14'h0000, loop_reg};
                        default: rdata_next = `XRD_ZERO16;
                    endcase
                end
            end
            default: rd_state_next = XRD_IDLE;
        endcase
    end

    // Management state registers
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            bit_rev_reg <= `XRD_BIT_REV_RESET;
            loop_reg <= `XRD_LOOP_RESET;
            coll_latch_reg <= 1'b0;
            sync_latch_reg <= 1'b0;
            rdata_reg <= `XRD_ZERO16;
            rvalid_reg <= 1'b0;
            rd_state_reg <= XRD_IDLE;
        end else begin
            bit_rev_reg <= bit_rev_next;
            loop_reg <= loop_next;
            coll_latch_reg <= coll_latch_next;
            sync_latch_reg <= sync_latch_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            rd_state_reg <= rd_state_next;
        end
    end

    // Vendor loopbacks are disabled whenever the standard loopback is on
    assign xaui_loop_on = loop_reg[`XRD_LOOP_XAUI] && !std_loopback;
    assign xgmii_loop_on = loop_reg[`XRD_LOOP_XGMII] && !std_loopback;

    // Reversal stages; XGMII sides treat each 8-bit lane
    xrd_bit_reverse #(.LANES(4), .LANE_W(8)) u_rev_xgmii_rx (
        .enable(bit_rev_reg[`XRD_REV_XGMII_RX]),
        .din(rx_decoded.data),
        .dout(rx_rev_data)
    );
    xrd_bit_reverse #(.LANES(4), .LANE_W(10)) u_rev_rx_a (
        .enable(bit_rev_reg[`XRD_REV_XAUI_RX]),
        .din(serdes_rx_a),
        .dout(rx_a_rev)
    );
    xrd_bit_reverse #(.LANES(4), .LANE_W(10)) u_rev_rx_b (
        .enable(bit_rev_reg[`XRD_REV_XAUI_RX]),
        .din(serdes_rx_b),
        .dout(rx_b_rev)
    );
    xrd_bit_reverse #(.LANES(4), .LANE_W(10)) u_rev_tx (
        .enable(bit_rev_reg[`XRD_REV_XAUI_TX]),
        .din(tx_encoded),
        .dout(tx_rev)
    );
    logic [31:0] tx_in_rev;
    xrd_bit_reverse #(.LANES(4), .LANE_W(8)) u_rev_xgmii_tx (
        .enable(bit_rev_reg[`XRD_REV_XGMII_TX]),
        .din(xgmii_tx_in.data),
        .dout(tx_in_rev)
    );

    // Loopback steering; reversal on B applies to channel B regardless
    always_comb begin
        tx_src.data = tx_in_rev;
        tx_src.ctrl = xgmii_tx_in.ctrl;
        if (xaui_loop_on) begin
            tx_src = rx_decoded;
        end
        rx_a_sel = xgmii_loop_on ? tx_encoded : rx_a_rev;
    end

    // Registered datapath outputs, one cycle of latency each
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            tx_core_reg <= '0;
            rx_out_reg <= '0;
            ser_tx_reg <= '0;
            rx_a_reg <= '0;
            rx_b_reg <= '0;
        end else begin
            tx_core_reg <= tx_src;
            rx_out_reg <= {rx_rev_data, rx_decoded.ctrl};
            ser_tx_reg <= tx_rev;
            rx_a_reg <= rx_a_sel;
            rx_b_reg <= rx_b_rev;
        end
    end

    assign mgmt_rdata = rdata_reg;
    assign mgmt_rvalid = rvalid_reg;
    assign xgmii_tx_core = tx_core_reg;
    assign xgmii_rx_out = rx_out_reg;
    assign serdes_tx_out = ser_tx_reg;
    assign rx_core_a = rx_a_reg;
    assign rx_core_b = rx_b_reg;
    assign bit_rev_ctrl = bit_rev_reg;
    assign loop_ctrl = loop_reg;
endmodule : xrd_diag_regs

// File: hw/xrd_lane_counter.sv
// Saturating, freeze-capable, clear-on-read code error counter
`timescale 1ns/1ps
`include "xrd_map.svh"
module xrd_lane_counter #(
    parameter int WIDTH = 16
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic code_err,
    input wire logic aligned,
    input wire logic rd_clear,
    output logic [WIDTH-1:0] count
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    // Next value; a read clears, an error in the same cycle then counts as one
    always_comb begin
        count_next = count_reg;
        if (rd_clear) begin
            count_next = `XRD_CNT_ZERO;
            if (code_err && aligned) begin
                count_next = `XRD_CNT_ONE;
            end
        end else if (code_err && aligned && count_reg != `XRD_CNT_MAX) begin
            count_next = WIDTH'(count_reg + `XRD_CNT_ONE);
        end
    end
    // Register
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            count_reg <= `XRD_CNT_RESET;
        end else begin
            count_reg <= count_next;
        end
    end
    assign count = count_reg;
endmodule : xrd_lane_counter

// File: shared/xrd_map.svh
// Register offsets, field positions, reset values and counter constants of the diagnostic bank
`ifndef XRD_MAP_SVH
`define XRD_MAP_SVH
`define XRD_ADDR_LANE1_CNT 16'h8011
`define XRD_ADDR_LANE2_CNT 16'h8012
`define XRD_ADDR_LANE3_CNT 16'h8013
`define XRD_ADDR_SYNC_STATE 16'h8014
`define XRD_ADDR_ALIGN_STAT 16'h8015
`define XRD_ADDR_SYNC_STAT 16'h8016
`define XRD_ADDR_BIT_REV 16'h8017
`define XRD_ADDR_LOOP_CTRL 16'h8018
`define XRD_CNT_RESET 16'hfffd
`define XRD_CNT_MAX 16'hffff
`define XRD_CNT_ONE 16'h0001
`define XRD_CNT_ZERO 16'h0000
`define XRD_BIT_REV_RESET 4'h5
`define XRD_LOOP_RESET 2'h0
`define XRD_REV_XGMII_RX 3
`define XRD_REV_XAUI_RX 2
`define XRD_REV_XGMII_TX 1
`define XRD_REV_XAUI_TX 0
`define XRD_LOOP_XAUI 1
`define XRD_LOOP_XGMII 0
`define XRD_SYNC_ALL_BIT 11
`define XRD_ALIGN_COLL_BIT 0
`define XRD_ZERO16 16'h0000
`endif

// File: shared/xrd_pkg.sv
// Types for the diagnostic bank
package xrd_pkg;
    // XGMII-side lane word: 32 data plus 4 control
    typedef struct packed {
        logic [31:0] data;
        logic [3:0] ctrl;
    } xrd_xgmii_t;
    // Management access request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } xrd_mgmt_req_t;
    // Management read state
    typedef enum logic [1:0] {XRD_IDLE, XRD_ANSWER} xrd_rd_state_t;
endpackage : xrd_pkg

// File: testbench/xrd_diag_regs_monitor.sv
// Port checker of the diagnostic register bank
`timescale 1ns/1ps
`include "xrd_map.svh"
module xrd_diag_regs_monitor
    import xrd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire xrd_mgmt_req_t mgmt_req,
    input wire logic [15:0] mgmt_rdata,
    input wire logic mgmt_rvalid,
    input wire logic std_loopback,
    input wire logic [11:0] sync_fsm_state,
    input wire logic [3:0] align_fsm_state,
    input wire xrd_xgmii_t xgmii_tx_in,
    input wire xrd_xgmii_t xgmii_tx_core,
    input wire xrd_xgmii_t rx_decoded,
    input wire logic [39:0] tx_encoded,
    input wire logic [39:0] serdes_tx_out,
    input wire logic [39:0] rx_core_a,
    input wire logic [3:0] bit_rev_ctrl,
    input wire logic [1:0] loop_ctrl
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    // Request steps, taken on the edge where the strobe is high
    sequence s_rd(a);
        mgmt_req.rd && mgmt_req.addr == a;
    endsequence
    sequence s_wr(a);
        mgmt_req.wr && mgmt_req.addr == a;
    endsequence
    AST_RD_ANSWER: assert property (mgmt_req.rd |=> mgmt_rvalid)
        else $error("read not answered");
    AST_NO_SPURIOUS: assert property (!mgmt_req.rd |=> !mgmt_rvalid)
        else $error("answer without read");
    AST_SYNC_FIELDS: assert property (
        s_rd(`XRD_ADDR_SYNC_STATE) |=> mgmt_rdata[11:0] == $past(sync_fsm_state))
        else $error("sync state fields wrong");
    AST_ALIGN_FIELD: assert property (
        s_rd(`XRD_ADDR_ALIGN_STAT) |=> mgmt_rdata[15:12] == $past(align_fsm_state))
        else $error("align state field wrong");
    AST_REV_WRITE: assert property (
        s_wr(`XRD_ADDR_BIT_REV) |=> bit_rev_ctrl == $past(mgmt_req.wdata[3:0]))
        else $error("reversal control not written");
    AST_XAUI_LOOP: assert property (
        loop_ctrl[1] && !std_loopback |=> xgmii_tx_core == $past(rx_decoded))
        else $error("receive word not looped to transmit");
    AST_XGMII_LOOP: assert property (
        loop_ctrl[0] && !std_loopback |=> rx_core_a == $past(tx_encoded))
        else $error("encoded word not looped to receive");
    // Standard loopback must override the vendor path
    AST_STD_WINS: assert property (
        loop_ctrl[1] && std_loopback && !bit_rev_ctrl[1] |=> xgmii_tx_core == $past(xgmii_tx_in))
        else $error("vendor loop active under standard loop");
    AST_TX_PLAIN: assert property (
        !bit_rev_ctrl[0] |=> serdes_tx_out == $past(tx_encoded))
        else $error("transmit word altered");
endmodule : xrd_diag_regs_monitor

// File: testbench/xrd_diag_regs_test.sv
// Self-checking bench of the diagnostic register bank
`timescale 1ns/1ps
`include "xrd_map.svh"
module xrd_diag_regs_test;
    import xrd_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    xrd_mgmt_req_t mgmt_req = '0;
    logic [15:0] mgmt_rdata;
    logic mgmt_rvalid;
    logic std_loopback = 1'b0;
    logic align_status = 1'b1;
    logic [3:1] code_err = 3'h0;
    logic [11:0] sync_fsm_state = 12'ha5c;
    logic [3:0] align_fsm_state = 4'h9;
    logic align_fifo_collision = 1'b0;
    logic all_lanes_synced = 1'b1;
    xrd_xgmii_t xgmii_tx_in, xgmii_tx_core, xgmii_rx_out;
    xrd_xgmii_t rx_decoded = '{data: 32'hc0ff_ee11, ctrl: 4'h5};
    logic [39:0] tx_encoded = 40'h01_2345_6789;
    logic [39:0] serdes_rx_a = 40'hfe_dcba_9876;
    logic [39:0] serdes_rx_b = 40'h3c_5a0f_e1d2;
    logic [39:0] serdes_tx_out, rx_core_a, rx_core_b;
    logic [3:0] bit_rev_ctrl;
    logic [1:0] loop_ctrl;
    int bad_count = 0;
    int num_checks = 0;
    always #50 clk_sys = ~clk_sys;
    xrd_mac_model MAC (.clk_sys(clk_sys), .xgmii_tx_in(xgmii_tx_in), .xgmii_rx_out(xgmii_rx_out));
    xrd_diag_regs DUT (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .mgmt_req(mgmt_req),
        .mgmt_rdata(mgmt_rdata),
        .mgmt_rvalid(mgmt_rvalid),
        .std_loopback(std_loopback),
        .align_status(align_status),
        .code_err(code_err),
        .sync_fsm_state(sync_fsm_state),
        .align_fsm_state(align_fsm_state),
        .align_fifo_collision(align_fifo_collision),
        .all_lanes_synced(all_lanes_synced),
        .xgmii_tx_in(xgmii_tx_in),
        .xgmii_tx_core(xgmii_tx_core),
        .rx_decoded(rx_decoded),
        .xgmii_rx_out(xgmii_rx_out),
        .tx_encoded(tx_encoded),
        .serdes_tx_out(serdes_tx_out),
        .serdes_rx_a(serdes_rx_a),
        .serdes_rx_b(serdes_rx_b),
        .rx_core_a(rx_core_a),
        .rx_core_b(rx_core_b),
        .bit_rev_ctrl(bit_rev_ctrl),
        .loop_ctrl(loop_ctrl)
    );
    // Per-lane reversal, computed apart from the design
    function automatic logic [39:0] rev10(input logic [39:0] v);
        for (int i = 0; i < 40; i++) rev10[i] = v[(i / 10) * 10 + 9 - i % 10];
    endfunction : rev10
    function automatic logic [31:0] rev8(input logic [31:0] v);
        for (int i = 0; i < 32; i++) rev8[i] = v[(i / 8) * 8 + 7 - i % 8];
    endfunction : rev8
    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
        mgmt_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(negedge clk_sys);
        mgmt_req.wr = 1'b0;
        @(negedge clk_sys);
    endtask : reg_wr
    // Answer stands one cycle after the taking edge; look while it stands
    task automatic reg_rd(input logic [15:0] a, input logic [15:0] exp);
        mgmt_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
        @(negedge clk_sys);
        check({23'h000000, mgmt_rvalid, mgmt_rdata}, {24'h000001, exp});
        mgmt_req.rd = 1'b0;
        @(negedge clk_sys);
    endtask : reg_rd
    // Datapath outputs one cycle on; r and l are the effective controls
    task automatic paths(input logic [3:0] r, input logic [1:0] l);
        xrd_xgmii_t t;
        // Take the word the design registers, not the one before the model's update
        @(posedge clk_sys);
        t = xgmii_tx_in;
        @(negedge clk_sys);
        check(xgmii_tx_core, l[1] ? rx_decoded : {r[1] ? rev8(t.data) : t.data, t.ctrl});
        check(xgmii_rx_out, {r[3] ? rev8(rx_decoded.data) : rx_decoded.data, rx_decoded.ctrl});
        check(rx_core_a, l[0] ? tx_encoded : r[2] ? rev10(serdes_rx_a) : serdes_rx_a);
        check(rx_core_b, r[2] ? rev10(serdes_rx_b) : serdes_rx_b);
        check(serdes_tx_out, r[0] ? rev10(tx_encoded) : tx_encoded);
    endtask : paths
    task automatic end_sim;
        $display("checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (16) @(negedge clk_sys);
        reset_n = 1'b1;
        paths(4'h5, 2'h0);
        // Lane 2 runs from its reset value into the ceiling
        code_err = 3'h2;
        repeat (4) @(negedge clk_sys);
        code_err = 3'h0;
        reg_rd(`XRD_ADDR_LANE2_CNT, `XRD_CNT_MAX);
        reg_rd(`XRD_ADDR_LANE2_CNT, `XRD_CNT_ZERO);
        reg_rd(`XRD_ADDR_LANE1_CNT, `XRD_CNT_RESET);
        reg_rd(`XRD_ADDR_LANE3_CNT, `XRD_CNT_RESET);
        // Lanes 1 and 3 count three, then freeze while unaligned
        code_err = 3'h5;
        repeat (3) @(negedge clk_sys);
        align_status = 1'b0;
        repeat (2) @(negedge clk_sys);
        code_err = 3'h0;
        align_status = 1'b1;
        reg_rd(`XRD_ADDR_LANE1_CNT, 16'h0003);
        reg_rd(`XRD_ADDR_LANE3_CNT, 16'h0003);
        reg_rd(`XRD_ADDR_LANE2_CNT, `XRD_CNT_ZERO);
        reg_wr(`XRD_ADDR_SYNC_STATE, 16'hffff);
        reg_rd(`XRD_ADDR_SYNC_STATE, 16'h0a5c);
        reg_rd(16'h8019, 16'h0000);
        // Latched bits hold until read, then follow the live level
        align_fifo_collision = 1'b1;
        @(negedge clk_sys);
        align_fifo_collision = 1'b0;
        reg_rd(`XRD_ADDR_ALIGN_STAT, 16'h9001);
        reg_rd(`XRD_ADDR_ALIGN_STAT, 16'h9000);
        reg_rd(`XRD_ADDR_SYNC_STAT, 16'h0000);
        reg_rd(`XRD_ADDR_SYNC_STAT, 16'h0800);
        all_lanes_synced = 1'b0;
        @(negedge clk_sys);
        all_lanes_synced = 1'b1;
        reg_rd(`XRD_ADDR_SYNC_STAT, 16'h0000);
        reg_rd(`XRD_ADDR_SYNC_STAT, 16'h0800);
        reg_rd(`XRD_ADDR_BIT_REV, 16'h0005);
        reg_rd(`XRD_ADDR_LOOP_CTRL, 16'h0000);
        reg_wr(`XRD_ADDR_BIT_REV, 16'h000f);
        paths(4'hf, 2'h0);
        check(bit_rev_ctrl, 4'hf);
        reg_wr(`XRD_ADDR_BIT_REV, 16'h0000);
        paths(4'h0, 2'h0);
        reg_wr(`XRD_ADDR_LOOP_CTRL, 16'h0003);
        paths(4'h0, 2'h3);
        check(loop_ctrl, 2'h3);
        std_loopback = 1'b1;
        paths(4'h0, 2'h0);
        std_loopback = 1'b0;
        reg_wr(`XRD_ADDR_LOOP_CTRL, 16'h0002);
        paths(4'h0, 2'h2);
        reg_rd(`XRD_ADDR_LOOP_CTRL, 16'h0002);
        end_sim();
    end
endmodule : xrd_diag_regs_test
bind xrd_diag_regs xrd_diag_regs_monitor MON (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .mgmt_req(mgmt_req),
    .mgmt_rdata(mgmt_rdata),
    .mgmt_rvalid(mgmt_rvalid),
    .std_loopback(std_loopback),
    .sync_fsm_state(sync_fsm_state),
    .align_fsm_state(align_fsm_state),
    .xgmii_tx_in(xgmii_tx_in),
    .xgmii_tx_core(xgmii_tx_core),
    .rx_decoded(rx_decoded),
    .tx_encoded(tx_encoded),
    .serdes_tx_out(serdes_tx_out),
    .rx_core_a(rx_core_a),
    .bit_rev_ctrl(bit_rev_ctrl),
    .loop_ctrl(loop_ctrl)
);

// File: testbench/xrd_mac_model.sv
// Transmit traffic source standing in for the MAC
`timescale 1ns/1ps
module xrd_mac_model
    import xrd_pkg::*;
(
    input wire logic clk_sys,
    output xrd_xgmii_t xgmii_tx_in,
    input wire xrd_xgmii_t xgmii_rx_out
);
    xrd_xgmii_t word_reg = '{data: 32'h0000_0001, ctrl: 4'h3};
    // New word every cycle, so a stale register cannot pass
    always @(negedge clk_sys) begin
        word_reg.data <= word_reg.data * 32'h0001_0003 + 32'h9e37_79b9;
        word_reg.ctrl <= ~word_reg.ctrl;
    end
    // One driver for the port; value is defined through reset too
    assign xgmii_tx_in = word_reg;
endmodule : xrd_mac_model
